// File: ilscr_top.sv
// Serial-bus slave with the register bank that drives eight current sinks

module ilscr_top (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    enable,
    input  wire logic                    over_temp,
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe,
    output ilscr_pkg::ilscr_sink_t [7:0] sink_drive
);

    ilscr_pkg::ilscr_state_t state;
    ilscr_pkg::ilscr_state_t next_state;
    ilscr_pkg::ilscr_state_t tgt;
    ilscr_pkg::ilscr_state_t next_tgt;
    logic [3:0]              cnt;
    logic [3:0]              next_cnt;
    logic [7:0]              sh;
    logic [7:0]              next_sh;
    logic [7:0]              ptr;
    logic [7:0]              next_ptr;
    logic                    oe;
    logic                    next_oe;
    logic                    scl_q;
    logic                    sda_q;
    logic                    wr_en;
    logic                    ptr_load;
    logic [7:0]              onoff;
    logic [7:0]              next_onoff;
    logic [5:0]              level [8];
    logic [5:0]              next_level [8];
    logic [3:0]              step;
    logic [3:0]              next_step;
    logic [7:0]              rd_data;
    ilscr_pkg::ilscr_sink_t [7:0] next_drive;

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = oe;

    // Pins are sampled once for edge detection
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Edges are seen per system clock, so any bus rate far below it works
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    // Start and repeated start look alike
    assign start_ev = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_ev  = scl_in & scl_q & ~sda_q & sda_in;

    // Read mux; unused bits and unmapped addresses give zero
    always_comb begin
        rd_data = 8'h00;
        if (ptr == ilscr_pkg::REG_ONOFF) begin
            rd_data = onoff;
        end else if (ptr == ilscr_pkg::REG_STEP) begin
            rd_data = {4'h0, step};
        end else if (ptr >= ilscr_pkg::REG_LEVEL1 && ptr <= ilscr_pkg::REG_LEVEL8) begin
            rd_data = {2'h0, level[3'(ptr - ilscr_pkg::REG_LEVEL1)]};
        end
    end

    // Bus sequencer
    always_comb begin
        next_state = state;
        next_tgt   = tgt;
        next_cnt   = cnt;
        next_sh    = sh;
        next_ptr   = ptr;
        next_oe    = oe;
        wr_en      = 1'b0;
        ptr_load   = 1'b0;
        if (!enable) begin
            next_state = ilscr_pkg::ST_IDLE;
            next_oe    = 1'b0;
            next_cnt   = 4'h0;
            next_ptr   = ilscr_pkg::RST_PTR;
        end else if (start_ev) begin
            next_state = ilscr_pkg::ST_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop_ev) begin
            // Pointer is left alone across a stop
            next_state = ilscr_pkg::ST_IDLE;
            next_oe    = 1'b0;
        end else begin
            case (state)
                ilscr_pkg::ST_ADDR, ilscr_pkg::ST_REG, ilscr_pkg::ST_DATA: begin
                    if (scl_rise && cnt != ilscr_pkg::BYTE_BITS) begin
                        next_sh  = {sh[6:0], sda_in};
                        next_cnt = 4'(cnt + 4'h1);
                    end else if (scl_fall && cnt == ilscr_pkg::BYTE_BITS) begin
                        next_cnt   = 4'h0;
                        next_oe    = 1'b1;
                        next_state = ilscr_pkg::ST_ACK;
                        if (state == ilscr_pkg::ST_ADDR) begin
                            // General call and ten-bit prefixes never match
                            if (sh[7:1] == ilscr_pkg::DEV_ADDR) begin
                                next_tgt = sh[0] ? ilscr_pkg::ST_TX : ilscr_pkg::ST_REG;
                            end else begin
                                next_oe    = 1'b0;
                                next_state = ilscr_pkg::ST_SKIP;
                            end
                        end else if (state == ilscr_pkg::ST_REG) begin
                            next_ptr = sh;
                            ptr_load = 1'b1;
                            next_tgt = ilscr_pkg::ST_DATA;
                        end else begin
                            // Extra data bytes rewrite the same register
                            wr_en    = 1'b1;
                            next_tgt = ilscr_pkg::ST_DATA;
                        end
                    end
                end
                ilscr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        next_state = tgt;
                        next_oe    = 1'b0;
                        next_cnt   = 4'h0;
                        if (tgt == ilscr_pkg::ST_TX) begin
                            next_sh = rd_data;
                            next_oe = ~rd_data[7];
                        end
                    end
                end
                ilscr_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == ilscr_pkg::LAST_TX_BIT) begin
                            next_state = ilscr_pkg::ST_MACK;
                            next_oe    = 1'b0;
                        end else begin
                            next_cnt = 4'(cnt + 4'h1);
                            next_sh  = {sh[6:0], 1'b0};
                            next_oe  = ~sh[6];
                        end
                    end
                end
                ilscr_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            next_state = ilscr_pkg::ST_SKIP;
                        end else begin
                            // Master wants more: resend the same register
                            next_state = ilscr_pkg::ST_ACK;
                            next_tgt   = ilscr_pkg::ST_TX;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ilscr_pkg::ST_IDLE;
            tgt   <= ilscr_pkg::ST_IDLE;
            cnt   <= 4'h0;
            sh    <= 8'h00;
            ptr   <= ilscr_pkg::RST_PTR;
            oe    <= 1'b0;
        end else begin
            state <= next_state;
            tgt   <= next_tgt;
            cnt   <= next_cnt;
            sh    <= next_sh;
            ptr   <= next_ptr;
            oe    <= next_oe;
        end
    end

    // Register bank
    always_comb begin
        next_onoff = onoff;
        next_level = level;
        next_step  = step;
        if (!enable) begin
            // Holding defaults while low also covers the rising edge
            next_onoff = ilscr_pkg::RST_ONOFF;
            next_step  = ilscr_pkg::RST_STEP;
            for (int k = 0; k < 8; k++) begin
                next_level[k] = ilscr_pkg::RST_LEVEL;
            end
        end else if (wr_en) begin
            if (ptr == ilscr_pkg::REG_ONOFF) begin
                next_onoff = sh;
            end else if (ptr == ilscr_pkg::REG_STEP) begin
                next_step = sh[3:0];
            end else if (ptr >= ilscr_pkg::REG_LEVEL1 && ptr <= ilscr_pkg::REG_LEVEL8) begin
                next_level[3'(ptr - ilscr_pkg::REG_LEVEL1)] = sh[5:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            onoff <= ilscr_pkg::RST_ONOFF;
            step  <= ilscr_pkg::RST_STEP;
            for (int k = 0; k < 8; k++) begin
                level[k] <= ilscr_pkg::RST_LEVEL;
            end
        end else begin
            onoff <= next_onoff;
            step  <= next_step;
            level <= next_level;
        end
    end

    // Per-sink drive; current in 31.25 uA units
    for (genvar i = 0; i < 8; i++) begin : g_sink
        logic [5:0] mult;
        logic       on_i;
        assign mult = (level[i] > ilscr_pkg::LEVEL_MAX) ? ilscr_pkg::LEVEL_MAX : level[i];
        assign on_i = enable & ~over_temp & onoff[i];
        assign next_drive[i] = {on_i,
            on_i ? 10'(10'(mult) * (10'(step) + 10'h001)) : 10'h000};
    end

    // One register stage for all sinks keeps a single driver on the output
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sink_drive <= '0;
        end else begin
            sink_drive <= next_drive;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    logic [9:0] sat_units;
    assign sat_units = 10'(10'(ilscr_pkg::LEVEL_MAX) * (10'(step) + 10'h001));

    sequence s_addr_done;
        enable && !start_ev && !stop_ev && state == ilscr_pkg::ST_ADDR
            && scl_fall && cnt == ilscr_pkg::BYTE_BITS;
    endsequence

    sequence s_ack_held;
        (sda_oe && state == ilscr_pkg::ST_ACK) [*1];
    endsequence

    AST_ADDR_ACK: assert property (
        s_addr_done and (sh[7:1] == ilscr_pkg::DEV_ADDR) |=> s_ack_held)
        else $error("matching address not acknowledged");

    AST_NO_GCALL: assert property (
        s_addr_done and (sh[7:1] == 7'h00) |=> !sda_oe && state == ilscr_pkg::ST_SKIP)
        else $error("general call was acknowledged");

    AST_NO_INC: assert property (
        $changed(ptr) |-> $past(ptr_load) || $past(!enable))
        else $error("register pointer moved without a register byte");

    AST_KEEP_PTR: assert property (
        enable && stop_ev |=> $stable(ptr) ##1 state == ilscr_pkg::ST_IDLE || start_ev)
        else $error("pointer lost across stop");

    AST_SAT: assert property (
        enable && !over_temp && onoff[1] && level[1] > ilscr_pkg::LEVEL_MAX
        |=> sink_drive[1].units == $past(sat_units))
        else $error("level code did not saturate at 50");

    AST_OT_OFF: assert property (
        over_temp |=> sink_drive == '0)
        else $error("sink on during over-temperature");

    AST_DEFAULTS: assert property (
        !enable |=> onoff == ilscr_pkg::RST_ONOFF && step == ilscr_pkg::RST_STEP
            && level[7] == ilscr_pkg::RST_LEVEL && !sda_oe)
        else $error("defaults not held while disabled");

    AST_UNUSED: assert property (
        ptr == ilscr_pkg::REG_STEP |-> rd_data[7:4] == 4'h0)
        else $error("unused step bits read nonzero");

    AST_HIGH_ZERO: assert property (
        ptr > ilscr_pkg::REG_STEP |-> rd_data == 8'h00)
        else $error("unmapped register read nonzero");

    AST_RESTART: assert property (
        enable && start_ev |=> state == ilscr_pkg::ST_ADDR && cnt == 4'h0 && !sda_oe)
        else $error("repeated start not taken");

endmodule

// File: ilscr_pkg.sv
// Shared constants and types for the LED sink control register slave
package ilscr_pkg;

    // Bus address of this slave, seven bits
    localparam logic [6:0] DEV_ADDR     = 7'h70;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [3:0] LAST_TX_BIT  = 4'h7;

    // Register offsets
    localparam logic [7:0] REG_ONOFF    = 8'h00;
    localparam logic [7:0] REG_LEVEL1   = 8'h01;
    localparam logic [7:0] REG_LEVEL8   = 8'h08;
    localparam logic [7:0] REG_STEP     = 8'h09;

    // Defaults loaded while enable is low
    localparam logic [7:0] RST_ONOFF    = 8'h00;
    localparam logic [5:0] RST_LEVEL    = 6'h01;
    localparam logic [3:0] RST_STEP     = 4'h8;
    localparam logic [7:0] RST_PTR      = 8'h00;

    // Level codes above this saturate
    localparam logic [5:0] LEVEL_MAX    = 6'h32;

    // Slave sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_REG  = 3'h2,
        ST_DATA = 3'h3,
        ST_ACK  = 3'h4,
        ST_TX   = 3'h5,
        ST_MACK = 3'h6,
        ST_SKIP = 3'h7
    } ilscr_state_t;

    // Drive to one sink; units counts 31.25 uA steps
    typedef struct packed {
        logic       on;
        logic [9:0] units;
    } ilscr_sink_t;

endpackage

// File: ilscr_bus_master.sv
// Bus master model that frames single-byte transfers on the serial clock and data lines
module ilscr_bus_master #(
    parameter int STARTUP_CYCLES = 35000
) (
    input  wire logic sys_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quarter of a bit time in clock cycles; raised by the bench for slow traffic
    int quarter = 8;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Every change lands just after an edge so the slave never sees a race
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wake();
        tick(STARTUP_CYCLES);
    endtask

    // Also serves as repeated start: clock is low whenever this is entered mid-frame
    task automatic start();
        tick(quarter);
        sda_drv = 1'b1;
        tick(quarter);
        scl = 1'b1;
        tick(quarter);
        sda_drv = 1'b0;
        tick(quarter);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(quarter);
        sda_drv = 1'b0;
        tick(quarter);
        scl = 1'b1;
        tick(quarter);
        sda_drv = 1'b1;
        tick(quarter);
    endtask

    task automatic clock_bit(input logic b, output logic r);
        tick(quarter);
        sda_drv = b;
        tick(quarter);
        scl = 1'b1;
        tick(2 * quarter);
        r = sda_wire;
        scl = 1'b0;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], r);
        end
        clock_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic fetch(output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, r);
            b[i] = r;
        end
        clock_bit(1'b1, r);
    endtask
endmodule

// File: test_ilscr_top.sv
// Self-checking bench for the LED sink control register slave
module test_ilscr_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic                         sys_clk   = 1'b0;
    logic                         arst_n    = 1'b0;
    logic                         enable    = 1'b0;
    logic                         over_temp = 1'b0;
    logic                         scl;
    logic                         sda_drv;
    logic                         sda_out;
    logic                         sda_oe;
    ilscr_pkg::ilscr_sink_t [7:0] sink_drive;
    wire                          sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
    int                           mismatches = 0;
    int                           cmp_count  = 0;
    int                           cycles     = 0;
    logic [7:0]                   m_on;
    logic [5:0]                   m_lvl [8];
    logic [3:0]                   m_step;
    logic [7:0]                   d;
    logic                         ack;

    always #5 sys_clk = ~sys_clk;

    ilscr_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .enable(enable), .over_temp(over_temp),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .sink_drive(sink_drive));

    // Start-up wait shortened so the run stays brief
    ilscr_bus_master #(.STARTUP_CYCLES(200)) m (.sys_clk(sys_clk), .sda_wire(sda_wire),
        .scl(scl), .sda_drv(sda_drv));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic model_defaults();
        m_on = 8'h00;
        m_step = 4'h8;
        foreach (m_lvl[i]) m_lvl[i] = 6'h01;
    endtask

    task automatic chk_sinks();
        logic       on;
        logic [5:0] sat;
        logic [9:0] u;
        for (int i = 0; i < 8; i++) begin
            on = m_on[i] & enable & ~over_temp;
            sat = (m_lvl[i] > 6'h32) ? 6'h32 : m_lvl[i];
            u = on ? ({4'h0, sat} * ({6'h00, m_step} + 10'h001)) : 10'h000;
            chk("sink_drive", {5'h00, on, u}, {5'h00, sink_drive[i]});
        end
    endtask

    task automatic send_chk(input logic [7:0] b, input logic exp_ack);
        m.send(b, ack);
        chk("ack", {15'h0000, exp_ack}, {15'h0000, ack});
    endtask

    task automatic wr_reg(input logic [7:0] r, input logic [7:0] v);
        m.start();
        send_chk(8'hE0, 1'b1);
        send_chk(r, 1'b1);
        send_chk(v, 1'b1);
        m.stop();
    endtask

    task automatic rd_reg(input logic [7:0] r, output logic [7:0] v);
        m.start();
        send_chk(8'hE0, 1'b1);
        send_chk(r, 1'b1);
        m.start();
        send_chk(8'hE1, 1'b1);
        m.fetch(v);
        m.stop();
    endtask

    task automatic t_defaults();
        for (int r = 0; r < 10; r++) begin
            rd_reg(8'(r), d);
            chk("reg", (r == 0) ? 16'h0000 : (r == 9) ? 16'h0008 : 16'h0001, {8'h00, d});
        end
        chk_sinks();
        $display("test defaults done");
    endtask

    task automatic t_fields();
        wr_reg(8'h09, 8'hFF);
        wr_reg(8'h01, 8'h14);
        wr_reg(8'h02, 8'hFF);
        wr_reg(8'h03, 8'h33);
        wr_reg(8'h00, 8'h87);
        m_step = 4'hF;
        m_lvl[0] = 6'h14;
        m_lvl[1] = 6'h3F;
        m_lvl[2] = 6'h33;
        m_on = 8'h87;
        chk_sinks();
        rd_reg(8'h09, d);
        chk("step", 16'h000F, {8'h00, d});
        rd_reg(8'h02, d);
        chk("level2", 16'h003F, {8'h00, d});
        wr_reg(8'h09, 8'h00);
        m_step = 4'h0;
        chk_sinks();
        $display("test fields done");
    endtask

    task automatic t_pointer();
        m.start();
        send_chk(8'hE0, 1'b1);
        send_chk(8'h03, 1'b1);
        m.stop();
        m.start();
        send_chk(8'hE2, 1'b0);
        m.stop();
        for (int k = 0; k < 2; k++) begin
            m.start();
            send_chk(8'hE1, 1'b1);
            m.fetch(d);
            m.stop();
            chk("kept pointer", 16'h0033, {8'h00, d});
        end
        m.start();
        send_chk(8'hE0, 1'b1);
        send_chk(8'h04, 1'b1);
        send_chk(8'h05, 1'b1);
        send_chk(8'h06, 1'b1);
        m.stop();
        m_lvl[3] = 6'h06;
        rd_reg(8'h04, d);
        chk("no increment", 16'h0006, {8'h00, d});
        rd_reg(8'h05, d);
        chk("next untouched", 16'h0001, {8'h00, d});
        $display("test pointer done");
    endtask

    task automatic t_refuse();
        logic [7:0] codes [3] = '{8'h00, 8'hF0, 8'hE4};
        foreach (codes[i]) begin
            m.start();
            send_chk(codes[i], 1'b0);
            send_chk(8'h00, 1'b0);
            m.stop();
        end
        wr_reg(8'h0A, 8'h55);
        rd_reg(8'h0A, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        chk_sinks();
        $display("test refuse done");
    endtask

    task automatic t_guard();
        over_temp = 1'b1;
        m.tick(3);
        chk_sinks();
        over_temp = 1'b0;
        m.tick(3);
        chk_sinks();
        enable = 1'b0;
        m.tick(3);
        chk_sinks();
        enable = 1'b1;
        model_defaults();
        m.wake();
        rd_reg(8'h01, d);
        chk("level1", 16'h0001, {8'h00, d});
        rd_reg(8'h09, d);
        chk("step", 16'h0008, {8'h00, d});
        $display("test guard done");
    endtask

    task automatic t_slow();
        // Bit time of 252 cycles, just under the fast-mode rate
        m.quarter = 63;
        wr_reg(8'h05, 8'h2A);
        rd_reg(8'h05, d);
        chk("slow read", 16'h002A, {8'h00, d});
        m.quarter = 8;
        $display("test slow done");
    endtask

    initial begin
        model_defaults();
        m.tick(20);
        arst_n = 1'b1;
        enable = 1'b1;
        m.wake();
        t_defaults();
        t_fields();
        t_pointer();
        t_refuse();
        t_guard();
        t_slow();
        print_verdict();
    end
endmodule
